// *** rtl/serial_mem_slave.sv ***
// Two-wire serial slave front end with 32K x 8 memory array
module serial_mem_slave
    import serial_mem_pkg::*;
#(
    parameter logic [TYPE_W-1:0] DEV_TYPE = DEV_TYPE_DEF
) (
    input  wire logic                             clk_i,     // System clock, 10 MHz
    input  wire logic                             nrst_i,    // Async reset, active low
    input  wire serial_mem_pkg::line_t            line_i,    // Serial clock and data pins
    input  wire logic [serial_mem_pkg::SEL_W-1:0] device_select_pins_i, // Select straps
    input  wire logic                             wp_i,      // Write protect, high protects
    output logic                                  sda_o,     // Data out level, always low
    output logic                                  sda_oe_o,  // Data pull-down enable
    output logic                                  busy_o,    // Addressed and in operation
    output logic                                  wr_done_o  // Pulse, byte stored
);

    import serial_mem_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    pins_t pins_raw;
    pins_t pins_s;
    line_t line_d1_q;

    assign pins_raw.line = line_i;
    assign pins_raw.sel  = device_select_pins_i;
    assign pins_raw.wp   = wp_i;

    pin_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (PINS_RST)
    ) u_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (pins_raw),
        .sync_o  (pins_s)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_d1_q <= PINS_RST.line;
        end else begin
            line_d1_q <= pins_s.line;
        end
    end

    // ------------------------------------------------------------------
    // Bus condition decode
    // ------------------------------------------------------------------
    wire scl_rise  = pins_s.line.scl & ~line_d1_q.scl;
    wire scl_fall  = ~pins_s.line.scl & line_d1_q.scl;
    wire scl_high  = pins_s.line.scl & line_d1_q.scl;
    // Both samples high, so a clock edge is never taken for a condition
    wire start_det = scl_high & line_d1_q.sda & ~pins_s.line.sda;
    wire stop_det  = scl_high & ~line_d1_q.sda & pins_s.line.sda;

    // ------------------------------------------------------------------
    // State and datapath registers
    // ------------------------------------------------------------------
    state_t            state_q;
    state_t            state_d;
    logic [BYTE_W-1:0] shift_q;
    logic [BYTE_W-1:0] shift_d;
    logic [3:0]        bit_cnt_q;
    logic [3:0]        bit_cnt_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic              oe_d;
    logic              wr_en;

    logic [BYTE_W-1:0] mem [MEM_DEPTH];
    // Combinational read, the latch is steady for a whole bit
    wire  [BYTE_W-1:0] rd_byte = mem[addr_q];

    // ------------------------------------------------------------------
    // Slave address and write checks
    // ------------------------------------------------------------------
    wire byte_done   = (bit_cnt_q == BITS_BYTE);
    wire type_match  = (shift_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
    wire sel_match   = (shift_q[SEL_MSB:SEL_LSB] == pins_s.sel);
    wire addr_match  = type_match & sel_match;
    wire rd_request  = shift_q[RW_BIT];
    // Unconnected straps resolve low through the pad pull-downs
    wire protected_w = pins_s.wp;
    wire [ADDR_W-1:0] addr_inc = addr_q + 15'h0001;
    wire sda_nack    = pins_s.line.sda;

    // ------------------------------------------------------------------
    // Shift and count steps
    // ------------------------------------------------------------------
    wire [BYTE_W-1:0] shift_in  = {shift_q[BYTE_W-2:0], pins_s.line.sda};
    wire [BYTE_W-1:0] shift_out = {shift_q[BYTE_W-2:0], 1'b0};
    wire [3:0]        bit_inc   = bit_cnt_q + 4'h1;
    // Pull low for a zero, release for a one
    wire              oe_first  = ~rd_byte[BYTE_W-1];
    wire              oe_next   = ~shift_q[BYTE_W-2];

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        state_d   = state_q;
        shift_d   = shift_q;
        bit_cnt_d = bit_cnt_q;
        addr_d    = addr_q;
        oe_d      = sda_oe_o;
        wr_en     = 1'b0;
        if (start_det) begin
            // Abort anything and wait for a slave address
            state_d   = ST_DEV;
            bit_cnt_d = BIT_CNT_RST;
            oe_d      = 1'b0;
        end else if (stop_det) begin
            state_d   = ST_IDLE;
            oe_d      = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE, ST_IGNORE: begin
                    // Released until the next start
                    oe_d = 1'b0;
                end
                ST_DEV, ST_AHI, ST_ALO, ST_WDATA: begin
                    if (scl_rise && !byte_done) begin
                        // Sample on the rising edge
                        shift_d   = shift_in;
                        bit_cnt_d = bit_inc;
                    end else if (scl_fall && byte_done) begin
                        bit_cnt_d = BIT_CNT_RST;
                        oe_d      = 1'b1;
                        case (state_q)
                            ST_DEV: begin
                                if (addr_match) begin
                                    state_d = ST_DEV_ACK;
                                end else begin
                                    state_d = ST_IGNORE;
                                    oe_d    = 1'b0;
                                end
                            end
                            ST_AHI: begin
                                // Top address bit is a don't care
                                addr_d[ADDR_W-1:BYTE_W] = shift_q[ADDR_W-BYTE_W-1:0];
                                state_d = ST_AHI_ACK;
                            end
                            ST_ALO: begin
                                addr_d[BYTE_W-1:0] = shift_q;
                                state_d = ST_ALO_ACK;
                            end
                            default: begin
                                if (protected_w) begin
                                    // No ack and no increment
                                    state_d = ST_IGNORE;
                                    oe_d    = 1'b0;
                                end else begin
                                    // Stored before the ack clock starts
                                    wr_en   = 1'b1;
                                    addr_d  = addr_inc;
                                    state_d = ST_WDATA_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_DEV_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_d = BIT_CNT_RST;
                        if (rd_request) begin
                            shift_d = rd_byte;
                            oe_d    = oe_first;
                            state_d = ST_RDATA;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = ST_AHI;
                        end
                    end
                end
                ST_AHI_ACK, ST_ALO_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        oe_d    = 1'b0;
                        state_d = (state_q == ST_AHI_ACK) ? ST_ALO : ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise && !byte_done) begin
                        bit_cnt_d = bit_inc;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            // Release for the master's ack
                            oe_d      = 1'b0;
                            bit_cnt_d = BIT_CNT_RST;
                            addr_d    = addr_inc;
                            state_d   = ST_RDATA_ACK;
                        end else begin
                            shift_d = shift_out;
                            oe_d    = oe_next;
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise && sda_nack) begin
                        // Master ended the read
                        state_d = ST_IDLE;
                    end else if (scl_fall) begin
                        shift_d = rd_byte;
                        oe_d    = oe_first;
                        state_d = ST_RDATA;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------
    // Low while a slave address is still arriving or after a refusal
    wire busy_d = (state_d != ST_IDLE) && (state_d != ST_IGNORE) && (state_d != ST_DEV);

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= BIT_CNT_RST;
        end else begin
            state_q   <= state_d;
            bit_cnt_q <= bit_cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Datapath registers
    // ------------------------------------------------------------------
    // The address latch survives a stop so a current address read follows on
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            shift_q   <= BYTE_RST;
            addr_q    <= ADDR_RST;
        end else begin
            shift_q   <= shift_d;
            addr_q    <= addr_d;
        end
    end

    // Open drain: level is fixed low, only the enable moves
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sda_o     <= 1'b0;
            sda_oe_o  <= 1'b0;
            busy_o    <= 1'b0;
            wr_done_o <= 1'b0;
        end else begin
            sda_o     <= 1'b0;
            sda_oe_o  <= oe_d;
            busy_o    <= busy_d;
            wr_done_o <= wr_en;
        end
    end

    // ------------------------------------------------------------------
    // Memory array, no reset so it maps to plain storage
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (wr_en) begin
            mem[addr_q] <= shift_q;
        end
    end

endmodule

// *** include/serial_mem_pkg.sv ***
// Package: constants and carrier types of the two-wire memory slave front end
package serial_mem_pkg;

    // ------------------------------------------------------------------
    // Memory geometry and slave address field widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned MEM_DEPTH   = 32768;
    localparam int unsigned BYTE_W      = 8;
    localparam int unsigned SEL_W       = 3;
    localparam int unsigned TYPE_W      = 4;

    // ------------------------------------------------------------------
    // Slave address byte layout
    // ------------------------------------------------------------------
    localparam int unsigned TYPE_MSB    = 7;
    localparam int unsigned TYPE_LSB    = 4;
    localparam int unsigned SEL_MSB     = 3;
    localparam int unsigned SEL_LSB     = 1;
    localparam int unsigned RW_BIT      = 0;

    // Device type code: value is arbitrary, override per system
    localparam logic [TYPE_W-1:0] DEV_TYPE_DEF = 4'h5;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST   = 15'h0000;
    localparam logic [BYTE_W-1:0] BYTE_RST   = 8'h00;
    localparam logic [3:0]        BIT_CNT_RST = 4'h0;
    localparam logic [3:0]        BITS_BYTE  = 4'h8;
    localparam int unsigned       SYNC_W     = 2 + SEL_W + 1;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } line_t;

    typedef struct packed {
        line_t            line;
        logic [SEL_W-1:0] sel;
        logic             wp;
    } pins_t;

    // Idle bus levels, so no false clock or data edge follows reset
    localparam pins_t PINS_RST = '{line: '{scl: 1'b1, sda: 1'b1}, sel: '0, wp: 1'b0};

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_DEV,
        ST_DEV_ACK,
        ST_AHI,
        ST_AHI_ACK,
        ST_ALO,
        ST_ALO_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK,
        ST_IGNORE
    } state_t;

endpackage

// *** rtl/pin_sync.sv ***
// Two-stage synchroniser for the asynchronous pin inputs
module pin_sync #(
    parameter int unsigned      WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_i,   // System clock
    input  wire logic             nrst_i,  // Async reset, active low
    input  wire logic [WIDTH-1:0] async_i, // Raw pin levels
    output logic      [WIDTH-1:0] sync_o   // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds the second stage only
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// *** testbench/bus_master_model.sv ***
// Bus master model: owns the serial clock, drives open-drain data
module bus_master_model
    import serial_mem_pkg::*;
(
    input  wire logic            clk_i,    // System clock
    input  wire logic            sda_oe_i, // Device pull-down enable
    output serial_mem_pkg::line_t line_o   // Resolved bus levels
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;
    // Pull-up wins unless a party pulls low
    assign line_o = '{scl: scl_q, sda: sda_q & ~sda_oe_i};

    task automatic hold(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic drive(input logic c, input logic d, input int n);
        scl_q <= c;
        sda_q <= d;
        hold(n);
    endtask

    task automatic start();
        drive(scl_q, 1'b1, 2);
        drive(1'b1, 1'b1, 4);
        drive(1'b1, 1'b0, 4);
        drive(1'b0, 1'b0, 2);
    endtask

    task automatic stop();
        drive(1'b0, 1'b0, 2);
        drive(1'b1, 1'b0, 4);
        drive(1'b1, 1'b1, 4);
    endtask

    // Data set mid-low, held through the high phase
    task automatic bit_x(input logic b, output logic r);
        drive(1'b0, b, 2);
        drive(1'b1, b, 2);
        r = line_o.sda;
        hold(2);
        drive(1'b0, b, 2);
    endtask

    // Master releases data as 1 while the device answers
    task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r,
                        output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r[i]);
        end
        bit_x(a, ak);
    endtask
endmodule

// *** testbench/slave_props.sv ***
// Checker: port timing relations of the two-wire memory slave
module slave_props
    import serial_mem_pkg::*;
(
    input wire logic                             clk_i,     // Clock
    input wire logic                             nrst_i,    // Reset
    input wire serial_mem_pkg::line_t            line_i,    // Bus levels
    input wire logic [serial_mem_pkg::SEL_W-1:0] device_select_pins_i, // Straps
    input wire logic                             wp_i,      // Protect
    input wire logic                             sda_o,     // Data level
    input wire logic                             sda_oe_o,  // Pull-down
    input wire logic                             busy_o,    // Busy
    input wire logic                             wr_done_o  // Stored
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_start;
        line_i.scl && $past(line_i.scl) && $fell(line_i.sda);
    endsequence
    sequence s_stop;
        line_i.scl && $past(line_i.scl) && $rose(line_i.sda);
    endsequence

    property p_drive_low_only; !sda_o; endproperty
    // Pin fall reaches the output 3-4 clocks late, so look back that far
    property p_oe_held; $past(line_i.scl, 3) && $past(line_i.scl, 4) |-> $stable(sda_oe_o);
    endproperty
    property p_wr_allowed; wr_done_o |-> !wp_i && !$past(wp_i, 6); endproperty
    property p_wr_acked; wr_done_o |-> busy_o ##[0:4] sda_oe_o; endproperty
    property p_wr_single; wr_done_o |=> !wr_done_o [*8]; endproperty
    property p_busy_on_ack; $rose(busy_o) |-> ##[0:3] sda_oe_o; endproperty
    property p_stop_abort; s_stop |-> ##[1:6] (!busy_o && !sda_oe_o); endproperty
    property p_start_abort; s_start |-> ##[1:6] (!busy_o && !sda_oe_o); endproperty

    a_drive_low_only: assert property (p_drive_low_only) else $error("data driven high");
    a_oe_held: assert property (p_oe_held) else $error("data moved while clock high");
    a_wr_allowed: assert property (p_wr_allowed) else $error("write while protected");
    a_wr_acked: assert property (p_wr_acked) else $error("stored byte not acked");
    a_wr_single: assert property (p_wr_single) else $error("store pulse too long");
    a_busy_on_ack: assert property (p_busy_on_ack) else $error("busy without ack");
    a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");
    a_start_abort: assert property (p_start_abort) else $error("start did not abort");
endmodule

bind serial_mem_slave slave_props props_u (.clk_i(clk_i), .nrst_i(nrst_i), .line_i(line_i),
    .device_select_pins_i(device_select_pins_i), .wp_i(wp_i), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .busy_o(busy_o), .wr_done_o(wr_done_o));

// *** testbench/testbench.sv ***
// Self-checking bench of the two-wire memory slave front end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import serial_mem_pkg::*;
    localparam logic [TYPE_W-1:0] TYPE_C = 4'h9; // Arbitrary type code
    logic             clk_i = 1'b0;
    logic             nrst_i = 1'b0;
    line_t            line_w;
    logic [SEL_W-1:0] sel_q = '0;
    logic             wp_q = 1'b0;
    logic             sda_w, oe_w, busy_w, done_w, ak;
    logic [7:0]       rd;
    logic [7:0]       wdat [3];
    int               fail_count = 0, check_count = 0, done_count = 0;

    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) done_count += int'(done_w === 1'b1);

    serial_mem_slave #(.DEV_TYPE(TYPE_C)) dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .line_i(line_w), .device_select_pins_i(sel_q), .wp_i(wp_q), .sda_o(sda_w),
        .sda_oe_o(oe_w), .busy_o(busy_w), .wr_done_o(done_w));
    bus_master_model master_u (.clk_i(clk_i), .sda_oe_i(oe_w), .line_o(line_w));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] slave_byte(input logic rw);
        return {TYPE_C, sel_q, rw};
    endfunction
    task automatic send(input logic [7:0] d, input logic exp_ak);
        master_u.xfer(d, 1'b1, rd, ak);
        check(8'(ak), 8'(exp_ak));
    endtask
    task automatic set_addr(input logic [14:0] a);
        master_u.start();
        send(slave_byte(1'b0), 1'b0);
        send({1'($urandom), a[14:8]}, 1'b0);
        send(a[7:0], 1'b0);
    endtask
    task automatic read1(input logic [7:0] exp);
        master_u.start();
        send(slave_byte(1'b1), 1'b0);
        master_u.xfer(8'hFF, 1'b1, rd, ak);
        check(rd, exp);
        master_u.stop();
    endtask
    task automatic finish_test();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(82));
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        sel_q <= 3'($urandom);
        foreach (wdat[i]) wdat[i] = 8'($urandom);
        master_u.hold(6);
        set_addr(15'h7FFE);
        check(8'(busy_w), 8'h01);
        foreach (wdat[i]) send(wdat[i], 1'b0);
        master_u.stop();
        check(8'(done_count), 8'h03);
        set_addr(15'h7FFE);
        master_u.start();
        send(slave_byte(1'b1), 1'b0);
        master_u.xfer(8'hFF, 1'b0, rd, ak);
        check(rd, wdat[0]);
        master_u.xfer(8'hFF, 1'b1, rd, ak);
        check(rd, wdat[1]);
        master_u.stop();
        read1(wdat[2]);
        $display("wrap write and read done");
        master_u.start();
        send({TYPE_C, sel_q ^ 3'h1, 1'b0}, 1'b1);
        send(8'h00, 1'b1);
        check(8'(busy_w), 8'h00);
        master_u.start();
        send({~TYPE_C, sel_q, 1'b0}, 1'b1);
        master_u.stop();
        $display("address mismatch done");
        sel_q <= '0;
        wp_q <= 1'b1;
        master_u.hold(8);
        set_addr(15'h0000);
        send(8'($urandom), 1'b1);
        master_u.stop();
        wp_q <= 1'b0;
        master_u.hold(8);
        $display("protected write done");
        set_addr(15'h0000);
        for (int i = 0; i < 4; i++) begin
            master_u.bit_x(1'b0, ak);
        end
        master_u.stop();
        check(8'(busy_w), 8'h00);
        check(8'(sda_w), 8'h00);
        read1(wdat[2]);
        check(8'(done_count), 8'h03);
        $display("aborted write done");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
endmodule
